// *** core/rcu_params.svh ***
// Register map, reset values, character codes and timing figures of the command utility.
`ifndef RCU_PARAMS_SVH
`define RCU_PARAMS_SVH
`define A_TOL        8'h00
`define A_EVT        8'h04
`define A_NOTE_START 8'h08
`define A_NOTE_IN    8'h0c
`define A_NOTE_OUT   8'h10
`define A_RADIX      8'h14
`define A_UNLOCK     8'h18
`define A_PUD        8'h1c
`define A_CAL_ITE    8'h20
`define A_CAL_VAL    8'h24
`define A_COND       8'h28
`define A_CAL_RDY    8'h2c
`define A_ERR        8'h30
`define UNLOCK_KEY   32'h0000a5c3
`define TOL_CUR_RST  16'h0064
`define TOL_WIN_RST  16'h1388
`define COND_RDY_BIT 11
`define TOK_DEC      24'h444543
`define TOK_HEX      24'h484558
`define TOK_BIN      24'h42494e
`define TOK_OCT      24'h4f4354
`define CASE_FOLD    24'hdfdfdf
`define PFX_HEX      8'h48
`define PFX_BIN      8'h42
`define PFX_OCT      8'h4f
`define CHR_SPACE    8'h20
`define CHR_QUOTE    8'h22
`define CHR_NULL     8'h00
`define NOTE_LAST    5'd16
`define REPLY_LAST   5'd17
`define ITE_LIM_MA   16'h0fa0
`define ITE_DRV_MA   16'h03e8
`define SENS_SHOW_MS 2000
`define MCLK_KHZ     25000
`endif

// *** core/rcu_pkg.sv ***
// Types shared by the command utility.
package rcu_pkg;
	typedef enum logic [1:0] {RAD_DEC, RAD_HEX, RAD_BIN, RAD_OCT} radix_t;
	typedef enum logic [1:0] {CAL_IDLE, CAL_ZERO, CAL_DRIVE, CAL_READY} cal_t;
endpackage

// *** core/remote_command_utility.sv ***
// Remote command utility: tolerance, user note, radix, unlock and cooler calibration.
// Operation
// - Tolerance flag change sets laser event bit.
// - Tolerance reply: current first, then window.
// - Any character accepted; null ends the note.
// - Short note padded with spaces.
// - Sixteen bytes end note; further characters ignored.
// - Stored note kept in nonvolatile memory.
// - Note reply is sixteen quoted bytes.
// - Never stored note replies all spaces.
// - Radix keyword recognised by three letters.
// - Status replies follow radix, with prefix.
// - Program data accepted in any radix.
// - Decimal at power-up; selection kept.
// - Radix query returns DEC, BIN, HEX, OCT.
// - Protected data write needs prior unlock.
// - Calibration locks panel, adjusts modes.
// - Calibration: current mode, cooler on, 4A/1A.
// - Readiness shown on condition bit 11.
// - Readiness query replies 1 or 0.
// - Local sensor calibration shows switch two seconds.
// - Local calibration beeps, enables set key.
// - Default tolerance 10.0 mA over 5 s.
`timescale 1ns/1ps
`include "rcu_params.svh"
module remote_command_utility #(
	parameter int unsigned SHOW_CYC = `SENS_SHOW_MS * `MCLK_KHZ
) (
	input  wire logic          mclk,
	input  wire logic          sys_rst,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic          inTolPin,
	input  wire logic          zeroDonePin,
	input  wire logic          localItePin,
	input  wire logic          localSensPin,
	input  wire logic [1:0]    sensSwPin,
	output logic               laserEvt,
	output rcu_pkg::radix_t    radixSel,
	output logic [7:0]         radixPfx,
	output logic               unlocked,
	output logic               pudWe,
	output logic [31:0]        pudData,
	output logic               nvWe,
	output logic               nvClr,
	output logic [3:0]         nvAddr,
	output logic [7:0]         nvData,
	output logic               panelLock,
	output logic               iteMode,
	output logic               coolerOn,
	output logic [15:0]        iteLimitMa,
	output logic [15:0]        iteSetMa,
	output logic               calReady,
	output logic               beep,
	output logic               setKeyEn,
	output logic               calValWe,
	output logic [31:0]        calValue,
	output logic               dispShow,
	output logic [1:0]         dispCode
);
	import rcu_pkg::*;

	logic [5:0]        syn1_q;
	logic [5:0]        syn2_q;
	logic              tolNow;
	logic              zeroDone;
	logic              locIte;
	logic              locSens;
	logic              setup;
	logic              wrEn;
	logic              rdEn;
	logic              hit;
	logic [31:0]       rdMux;
	logic [23:0]       radTok;
	logic              radOk;
	radix_t            radNew;
	logic [7:0]        noteByte;
	logic              noteChar;
	logic [31:0]       prdata_q, prdata_d;
	logic              slvErr_q, slvErr_d;
	logic [15:0]       tolCur_q, tolCur_d;
	logic [15:0]       tolWin_q, tolWin_d;
	logic              tolPrev_q, tolPrev_d;
	logic              evt_q, evt_d;
	logic              err_q, err_d;
	radix_t            radix_q, radix_d;
	logic              unlock_q, unlock_d;
	logic              pudWe_q, pudWe_d;
	logic [31:0]       pud_q, pud_d;
	logic [15:0][7:0]  note_q, note_d;
	logic [4:0]        idx_q, idx_d;
	logic              open_q, open_d;
	logic [4:0]        outPtr_q, outPtr_d;
	logic              nvWe_q, nvWe_d;
	logic              nvClr_q, nvClr_d;
	logic [3:0]        nvAddr_q, nvAddr_d;
	logic [7:0]        nvData_q, nvData_d;
	cal_t              state_q, state_d;
	logic              half_q, half_d;
	logic              beep_q, beep_d;
	logic              calWe_q, calWe_d;
	logic [31:0]       calVal_q, calVal_d;
	logic              locIPrev_q, locIPrev_d;
	logic              locSPrev_q, locSPrev_d;
	logic [31:0]       dispCnt_q, dispCnt_d;
	logic [1:0]        dispCode_q, dispCode_d;

	// Every pin is foreign to mclk, so all of them pass two flops before use.
	always_ff @(posedge mclk) begin
		syn1_q <= {sensSwPin, localSensPin, localItePin, zeroDonePin, inTolPin};
		syn2_q <= syn1_q;
	end
	assign tolNow   = syn2_q[0];
	assign zeroDone = syn2_q[1];
	assign locIte   = syn2_q[2];
	assign locSens  = syn2_q[3];

	// Bus phases; read data is latched in setup so it comes from a flop in access.
	assign setup    = psel && !penable;
	assign wrEn     = psel && penable && pwrite;
	assign rdEn     = psel && penable && !pwrite;
	assign pready   = 1'b1;
	assign prdata   = prdata_q;
	assign pslverr  = slvErr_q;
	assign noteChar = wrEn && paddr == `A_NOTE_IN && open_q;

	// Reply byte stream: quote, sixteen note bytes, quote.
	always_comb begin
		if (outPtr_q == 5'd0 || outPtr_q == `REPLY_LAST) begin
			noteByte = `CHR_QUOTE;
		end else begin
			noteByte = note_q[4'(outPtr_q - 5'd1)];
		end
	end

	// Keyword check folds case and looks at three letters only.
	always_comb begin
		radTok = pwdata[23:0] & `CASE_FOLD;
		radOk  = 1'b1;
		radNew = RAD_DEC;
		unique case (radTok)
			`TOK_DEC: radNew = RAD_DEC;
			`TOK_HEX: radNew = RAD_HEX;
			`TOK_BIN: radNew = RAD_BIN;
			`TOK_OCT: radNew = RAD_OCT;
			default:  radOk = 1'b0;
		endcase
	end

	// Address decode and read multiplexer.
	always_comb begin
		hit   = 1'b1;
		rdMux = 32'h0;
		case (paddr)
			`A_TOL:        rdMux = {tolWin_q, tolCur_q};
			`A_EVT:        rdMux = {31'h0, evt_q};
			`A_NOTE_START: rdMux = 32'h0;
			`A_NOTE_IN:    rdMux = 32'h0;
			`A_NOTE_OUT:   rdMux = {24'h0, noteByte};
			`A_RADIX: begin
				unique case (radix_q)
					RAD_DEC: rdMux = {8'h0, `TOK_DEC};
					RAD_HEX: rdMux = {8'h0, `TOK_HEX};
					RAD_BIN: rdMux = {8'h0, `TOK_BIN};
					RAD_OCT: rdMux = {8'h0, `TOK_OCT};
				endcase
			end
			`A_UNLOCK:     rdMux = {31'h0, unlock_q};
			`A_PUD:        rdMux = pud_q;
			`A_CAL_ITE:    rdMux = {30'h0, state_q};
			`A_CAL_VAL:    rdMux = calVal_q;
			`A_COND:       rdMux = 32'(calReady) << `COND_RDY_BIT;
			`A_CAL_RDY:    rdMux = {31'h0, calReady};
			`A_ERR:        rdMux = {31'h0, err_q};
			default:       hit = 1'b0;
		endcase
	end

	// Bus registers; read-to-clear flags clear first so a same-cycle set wins.
	always_comb begin
		prdata_d  = prdata_q;
		slvErr_d  = slvErr_q;
		tolCur_d  = tolCur_q;
		tolWin_d  = tolWin_q;
		tolPrev_d = tolNow;
		evt_d     = evt_q;
		err_d     = err_q;
		radix_d   = radix_q;
		unlock_d  = unlock_q;
		pudWe_d   = 1'b0;
		pud_d     = pud_q;
		if (setup) begin
			prdata_d = rdMux;
			slvErr_d = !hit;
		end
		if (rdEn && paddr == `A_EVT) evt_d = 1'b0;
		if (rdEn && paddr == `A_ERR) err_d = 1'b0;
		if (wrEn) begin
			case (paddr)
				`A_TOL: begin
					tolCur_d = pwdata[15:0];
					tolWin_d = pwdata[31:16];
				end
				`A_RADIX: begin
					if (radOk) radix_d = radNew;
					else err_d = 1'b1;
				end
				`A_UNLOCK: begin
					if (pwdata == `UNLOCK_KEY) unlock_d = 1'b1;
					else err_d = 1'b1;
				end
				`A_PUD: begin
					if (unlock_q) begin
						pudWe_d = 1'b1;
						pud_d   = pwdata;
					end else begin
						err_d = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (tolNow != tolPrev_q) evt_d = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			prdata_q  <= 32'h0;
			slvErr_q  <= 1'b0;
			tolCur_q  <= `TOL_CUR_RST;
			tolWin_q  <= `TOL_WIN_RST;
			tolPrev_q <= 1'b0;
			evt_q     <= 1'b0;
			err_q     <= 1'b0;
			radix_q   <= RAD_DEC;
			unlock_q  <= 1'b0;
			pudWe_q   <= 1'b0;
			pud_q     <= 32'h0;
		end else begin
			prdata_q  <= prdata_d;
			slvErr_q  <= slvErr_d;
			tolCur_q  <= tolCur_d;
			tolWin_q  <= tolWin_d;
			tolPrev_q <= tolPrev_d;
			evt_q     <= evt_d;
			err_q     <= err_d;
			radix_q   <= radix_d;
			unlock_q  <= unlock_d;
			pudWe_q   <= pudWe_d;
			pud_q     <= pud_d;
		end
	end

	// Note store: start fills spaces, each byte is mirrored to the nonvolatile store.
	always_comb begin
		note_d   = note_q;
		idx_d    = idx_q;
		open_d   = open_q;
		outPtr_d = outPtr_q;
		nvWe_d   = 1'b0;
		nvClr_d  = 1'b0;
		nvAddr_d = nvAddr_q;
		nvData_d = nvData_q;
		if (wrEn && paddr == `A_NOTE_START) begin
			note_d  = {16{`CHR_SPACE}};
			idx_d   = 5'd0;
			open_d  = 1'b1;
			nvClr_d = 1'b1;
		end else if (noteChar) begin
			if (pwdata[7:0] == `CHR_NULL) begin
				open_d = 1'b0;
			end else begin
				note_d[idx_q[3:0]] = pwdata[7:0];
				nvWe_d   = 1'b1;
				nvAddr_d = idx_q[3:0];
				nvData_d = pwdata[7:0];
				idx_d    = idx_q + 5'd1;
				if (idx_q == `NOTE_LAST - 5'd1) open_d = 1'b0;
			end
		end
		if (rdEn && paddr == `A_NOTE_OUT) begin
			outPtr_d = (outPtr_q == `REPLY_LAST) ? 5'd0 : outPtr_q + 5'd1;
		end
	end

	// Reset models power-up of an unwritten store, which reads back as spaces.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			note_q   <= {16{`CHR_SPACE}};
			idx_q    <= 5'd0;
			open_q   <= 1'b0;
			outPtr_q <= 5'd0;
			nvWe_q   <= 1'b0;
			nvClr_q  <= 1'b0;
			nvAddr_q <= 4'h0;
			nvData_q <= 8'h0;
		end else begin
			note_q   <= note_d;
			idx_q    <= idx_d;
			open_q   <= open_d;
			outPtr_q <= outPtr_d;
			nvWe_q   <= nvWe_d;
			nvClr_q  <= nvClr_d;
			nvAddr_q <= nvAddr_d;
			nvData_q <= nvData_d;
		end
	end

	// Cooler current calibration: two halves, each ending with an accepted value.
	always_comb begin
		state_d    = state_q;
		half_d     = half_q;
		beep_d     = 1'b0;
		calWe_d    = 1'b0;
		calVal_d   = calVal_q;
		locIPrev_d = locIte;
		locSPrev_d = locSens;
		dispCnt_d  = (dispCnt_q != 32'h0) ? dispCnt_q - 32'h1 : 32'h0;
		dispCode_d = dispCode_q;
		unique case (state_q)
			CAL_IDLE: begin
				if ((wrEn && paddr == `A_CAL_ITE) || (locIte && !locIPrev_q)) begin
					state_d = CAL_ZERO;
					half_d  = 1'b0;
				end
			end
			CAL_ZERO: if (zeroDone) state_d = CAL_DRIVE;
			CAL_DRIVE: begin
				state_d = CAL_READY;
				beep_d  = 1'b1;
			end
			CAL_READY: begin
				if (wrEn && paddr == `A_CAL_VAL) begin
					calWe_d  = 1'b1;
					calVal_d = pwdata;
					half_d   = 1'b1;
					state_d  = half_q ? CAL_IDLE : CAL_DRIVE;
				end
			end
		endcase
		if (locSens && !locSPrev_q) begin
			dispCnt_d  = SHOW_CYC;
			dispCode_d = syn2_q[5:4];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q    <= CAL_IDLE;
			half_q     <= 1'b0;
			beep_q     <= 1'b0;
			calWe_q    <= 1'b0;
			calVal_q   <= 32'h0;
			locIPrev_q <= 1'b0;
			locSPrev_q <= 1'b0;
			dispCnt_q  <= 32'h0;
			dispCode_q <= 2'b00;
		end else begin
			state_q    <= state_d;
			half_q     <= half_d;
			beep_q     <= beep_d;
			calWe_q    <= calWe_d;
			calVal_q   <= calVal_d;
			locIPrev_q <= locIPrev_d;
			locSPrev_q <= locSPrev_d;
			dispCnt_q  <= dispCnt_d;
			dispCode_q <= dispCode_d;
		end
	end

	// Outputs; the status formatter downstream takes radix and prefix from here.
	assign laserEvt   = evt_q;
	assign radixSel   = radix_q;
	assign radixPfx   = (radix_q == RAD_HEX) ? `PFX_HEX :
	                    (radix_q == RAD_BIN) ? `PFX_BIN :
	                    (radix_q == RAD_OCT) ? `PFX_OCT : 8'h00;
	assign unlocked   = unlock_q;
	assign pudWe      = pudWe_q;
	assign pudData    = pud_q;
	assign nvWe       = nvWe_q;
	assign nvClr      = nvClr_q;
	assign nvAddr     = nvAddr_q;
	assign nvData     = nvData_q;
	assign panelLock  = state_q != CAL_IDLE;
	assign iteMode    = state_q != CAL_IDLE;
	assign coolerOn   = state_q != CAL_IDLE;
	assign iteLimitMa = (state_q == CAL_READY) ? `ITE_LIM_MA : 16'h0;
	assign iteSetMa   = (state_q == CAL_READY) ? `ITE_DRV_MA : 16'h0;
	assign calReady   = state_q == CAL_READY;
	assign beep       = beep_q;
	assign setKeyEn   = state_q == CAL_READY;
	assign calValWe   = calWe_q;
	assign calValue   = calVal_q;
	assign dispShow   = dispCnt_q != 32'h0;
	assign dispCode   = dispCode_q;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence sCalEnter;
		state_q == CAL_IDLE && wrEn && paddr == `A_CAL_ITE;
	endsequence
	sequence sCalValue;
		calReady && wrEn && paddr == `A_CAL_VAL;
	endsequence

	a_tol_event: assert property ((tolNow != tolPrev_q) |=> evt_q)
		else $error("tolerance change did not set event");
	a_tol_reply: assert property (setup && paddr == `A_TOL
		|=> prdata == {tolWin_q, tolCur_q})
		else $error("tolerance reply order wrong");
	a_note_null: assert property (noteChar && pwdata[7:0] == `CHR_NULL |=> !open_q)
		else $error("null did not end note");
	a_note_full: assert property (noteChar && idx_q == 5'd15 && pwdata[7:0] != `CHR_NULL
		|=> !open_q && idx_q == `NOTE_LAST)
		else $error("note not closed at sixteen");
	a_note_pad: assert property (wrEn && paddr == `A_NOTE_START
		|=> note_q == {16{`CHR_SPACE}})
		else $error("note not space filled");
	a_nv_mirror: assert property (noteChar && pwdata[7:0] != `CHR_NULL
		|=> nvWe && nvData == $past(pwdata[7:0]))
		else $error("note byte not mirrored");
	a_reply_wrap: assert property (rdEn && paddr == `A_NOTE_OUT && outPtr_q == `REPLY_LAST
		|=> outPtr_q == 5'd0)
		else $error("reply not eighteen bytes");
	a_radix_bad: assert property (wrEn && paddr == `A_RADIX && !radOk
		|=> radix_q == $past(radix_q) && err_q)
		else $error("bad radix not refused");
	a_pud_lock: assert property (wrEn && paddr == `A_PUD && !unlock_q |=> !pudWe)
		else $error("protected write while locked");
	a_cal_enter: assert property (sCalEnter
		|=> panelLock && coolerOn && state_q == CAL_ZERO)
		else $error("calibration entry wrong");
	a_cal_drive: assert property (state_q == CAL_DRIVE
		|=> calReady && beep && iteLimitMa == `ITE_LIM_MA && iteSetMa == `ITE_DRV_MA)
		else $error("calibration drive wrong");
	a_ready_clear: assert property (sCalValue |=> !calReady && calValWe)
		else $error("ready not cleared");
	a_disp_show: assert property (locSens && !locSPrev_q
		|=> dispShow && dispCode == $past(syn2_q[5:4]))
		else $error("switch position not shown");
endmodule

// *** testbench/cooler_note_model.sv ***
// Far-side model: cooler zero-offset measurement and the nonvolatile note store.
`timescale 1ns/1ps
`include "rcu_params.svh"
module cooler_note_model #(
	parameter int ZERO_CYC = 8
) (
	input  wire logic       mclk,
	input  wire logic       coolerOn,
	input  wire logic       nvWe,
	input  wire logic       nvClr,
	input  wire logic [3:0] nvAddr,
	input  wire logic [7:0] nvData,
	output logic            zeroDonePin
);
	logic [7:0] store [16];
	int         cnt;

	// A store that was never written holds spaces, as a blank part would.
	initial begin
		for (int k = 0; k < 16; k++) store[k] = `CHR_SPACE;
		zeroDonePin = 1'b0;
		cnt = 0;
	end

	// Bytes persist here across resets of the block, like real nonvolatile cells.
	always @(posedge mclk) begin
		if (nvClr) begin
			for (int k = 0; k < 16; k++) store[k] <= `CHR_SPACE;
		end else if (nvWe) begin
			store[nvAddr] <= nvData;
		end
	end

	// The offset measurement takes a while, so readiness cannot come early.
	always @(posedge mclk) begin
		if (!coolerOn) begin
			cnt <= 0;
			zeroDonePin <= 1'b0;
		end else if (cnt < ZERO_CYC) begin
			cnt <= cnt + 1;
		end else begin
			zeroDonePin <= 1'b1;
		end
	end
endmodule

// *** testbench/remote_command_utility_tb.sv ***
// Self-checking bench for the remote command utility.
`timescale 1ns/1ps
`include "rcu_params.svh"
module remote_command_utility_tb;
	import rcu_pkg::*;
	localparam int SHOW = 20;
	logic        mclk, sysRst, psel, penable, pwrite, pready, pslverr, err;
	logic        inTolPin, zeroDonePin, localItePin, localSensPin, laserEvt;
	logic        unlocked, pudWe, nvWe, nvClr, panelLock, iteMode, coolerOn;
	logic        calReady, beep, setKeyEn, calValWe, dispShow;
	logic [7:0]  paddr, radixPfx, nvData, b;
	logic [31:0] pwdata, prdata, pudData, calValue, rd, v;
	logic [3:0]  nvAddr;
	logic [15:0] iteLimitMa, iteSetMa;
	logic [1:0]  sensSwPin, dispCode;
	radix_t      radixSel;
	logic [7:0]  expNote [16];
	logic [23:0] tok [4] = '{`TOK_DEC, `TOK_HEX, `TOK_BIN, `TOK_OCT};
	logic [7:0]  pfx [4] = '{8'h00, `PFX_HEX, `PFX_BIN, `PFX_OCT};
	int          errors, checks, seed, beeps, pudWes, calWes, i, j, n, len;

	remote_command_utility #(.SHOW_CYC(SHOW)) i_remote_command_utility (.mclk(mclk),
		.sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.inTolPin(inTolPin), .zeroDonePin(zeroDonePin), .localItePin(localItePin),
		.localSensPin(localSensPin), .sensSwPin(sensSwPin), .laserEvt(laserEvt),
		.radixSel(radixSel), .radixPfx(radixPfx), .unlocked(unlocked), .pudWe(pudWe),
		.pudData(pudData), .nvWe(nvWe), .nvClr(nvClr), .nvAddr(nvAddr), .nvData(nvData),
		.panelLock(panelLock), .iteMode(iteMode), .coolerOn(coolerOn),
		.iteLimitMa(iteLimitMa), .iteSetMa(iteSetMa), .calReady(calReady), .beep(beep),
		.setKeyEn(setKeyEn), .calValWe(calValWe), .calValue(calValue),
		.dispShow(dispShow), .dispCode(dispCode));

	cooler_note_model i_cooler_note_model (.mclk(mclk), .coolerOn(coolerOn), .nvWe(nvWe),
		.nvClr(nvClr), .nvAddr(nvAddr), .nvData(nvData), .zeroDonePin(zeroDonePin));

	// Free-running 25 MHz clock.
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// Pulses last one cycle, so they are counted rather than sampled.
	always @(posedge mclk) begin
		if (beep === 1'b1) beeps <= beeps + 1;
		if (pudWe === 1'b1) pudWes <= pudWes + 1;
		if (calValWe === 1'b1) calWes <= calWes + 1;
	end

	task automatic final_report;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		// Only the watchdog ends a wait for a slave that never answers.
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Condition word with only the readiness bit at the given level.
	function automatic logic [31:0] condWord(input logic rdy);
		logic [31:0] w;
		w = 32'h0;
		w[`COND_RDY_BIT] = rdy;
		return w;
	endfunction

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	// Reads the whole quoted reply and the far-side store against expNote.
	task automatic noteRead;
		rdchk("noteOpen", `A_NOTE_OUT, `CHR_QUOTE);
		for (int k = 0; k < 16; k++) begin
			rdchk("noteByte", `A_NOTE_OUT, expNote[k]);
			chk("nvStore", expNote[k], i_cooler_note_model.store[k]);
		end
		rdchk("noteClose", `A_NOTE_OUT, `CHR_QUOTE);
	endtask

	task automatic waitRdy;
		for (int k = 0; k < 100 && calReady !== 1'b1; k++) begin
			@(posedge mclk);
			#1;
		end
	endtask

	// Watchdog sized well beyond the expected several hundred cycles.
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		final_report();
	end

	initial begin
		seed = 23;
		errors = 0;
		checks = 0;
		beeps = 0;
		pudWes = 0;
		calWes = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{inTolPin, localItePin, localSensPin, sensSwPin} = '0;
		sysRst = 1'b1;
		repeat (6) @(posedge mclk);
		sysRst <= 1'b0;
		for (i = 0; i < 16; i++) expNote[i] = `CHR_SPACE;
		rdchk("tolReset", `A_TOL, {`TOL_WIN_RST, `TOL_CUR_RST});
		chk("radixReset", RAD_DEC, radixSel);
		rdchk("evtReset", `A_EVT, 32'h0);
		rdchk("rdyIdle", `A_CAL_RDY, 32'h0);
		noteRead();
		// Every keyword, alternating case, then an unknown one that must be refused.
		for (i = 0; i < 5; i++) begin
			v = (i < 4) ? {8'h0, tok[i]} : 32'h0058595a;
			if (i % 2 == 1) v = v ^ 32'h00202020;
			apb(1'b1, `A_RADIX, v);
			j = (i < 4) ? i : 3;
			#1;
			chk("radixSel", j, radixSel);
			chk("radixPfx", pfx[j], radixPfx);
			rdchk("radixTok", `A_RADIX, {8'h0, tok[j]});
		end
		rdchk("radixErr", `A_ERR, 32'h1);
		// Program data in range, taken whatever radix is selected.
		for (i = 0; i < 3; i++) begin
			v[15:0] = 16'($unsigned($random(seed)) % 1000 + 1);
			v[31:16] = 16'($unsigned($random(seed)) % 50000 + 1);
			apb(1'b1, `A_TOL, v);
			rdchk("tolBack", `A_TOL, v);
		end
		chk("radixKept", RAD_OCT, radixSel);
		// Each tolerance crossing sets a sticky event that a read clears.
		for (i = 0; i < 3; i++) begin
			@(posedge mclk);
			inTolPin <= ~inTolPin;
			repeat (6) @(posedge mclk);
			#1;
			chk("laserEvt", 1, laserEvt);
			rdchk("evtSet", `A_EVT, 32'h1);
			rdchk("evtClr", `A_EVT, 32'h0);
		end
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapErr", 1, err);
		// Short notes ended by null, then full notes with a byte too many.
		for (i = 0; i < 4; i++) begin
			len = (i < 2) ? $unsigned($random(seed)) % 15 + 1 : 16;
			apb(1'b1, `A_NOTE_START, 32'h0);
			for (j = 0; j < 16; j++) expNote[j] = `CHR_SPACE;
			for (j = 0; j < len; j++) begin
				b = 8'($unsigned($random(seed)) % 127 + 1);
				expNote[j] = b;
				apb(1'b1, `A_NOTE_IN, {24'h0, b});
			end
			if (len < 16) apb(1'b1, `A_NOTE_IN, 32'h0);
			apb(1'b1, `A_NOTE_IN, 32'h41);
			noteRead();
		end
		// Protected data stays put until the right key has been given.
		apb(1'b0, `A_PUD, 32'h0);
		v = rd;
		apb(1'b1, `A_PUD, ~v);
		rdchk("pudLocked", `A_PUD, v);
		rdchk("pudErr", `A_ERR, 32'h1);
		apb(1'b1, `A_UNLOCK, `UNLOCK_KEY ^ 32'h1);
		#1;
		chk("badKey", 0, unlocked);
		apb(1'b1, `A_UNLOCK, `UNLOCK_KEY);
		#1;
		chk("unlocked", 1, unlocked);
		v = $random(seed);
		apb(1'b1, `A_PUD, v);
		rdchk("pudOpen", `A_PUD, v);
		chk("pudData", v, pudData);
		chk("pudWes", 1, pudWes);
		// Two calibration runs, remote then local, each with two values.
		for (i = 0; i < 2; i++) begin
			apb(1'b1, `A_CAL_VAL, 32'h0000005a);
			if (i == 0) apb(1'b1, `A_CAL_ITE, 32'h0);
			else begin
				@(posedge mclk);
				localItePin <= 1'b1;
				repeat (4) @(posedge mclk);
				localItePin <= 1'b0;
			end
			repeat (4) @(posedge mclk);
			#1;
			chk("calModes", 3'b111, {panelLock, iteMode, coolerOn});
			chk("earlyRdy", 0, calReady);
			n = beeps;
			for (j = 0; j < 2; j++) begin
				waitRdy();
				chk("iteLimit", `ITE_LIM_MA, iteLimitMa);
				chk("iteSet", `ITE_DRV_MA, iteSetMa);
				chk("setKeyEn", 1, setKeyEn);
				rdchk("condRdy", `A_COND, condWord(1'b1));
				rdchk("rdyQuery", `A_CAL_RDY, 32'h1);
				chk("beeps", n + j + 1, beeps);
				v = $random(seed);
				apb(1'b1, `A_CAL_VAL, v);
				#1;
				chk("rdyCleared", 0, calReady);
				repeat (2) @(posedge mclk);
				#1;
				chk("calValue", v, calValue);
			end
			repeat (3) @(posedge mclk);
			#1;
			chk("calDone", 4'b0000, {panelLock, calReady, iteSetMa == 16'h0 ? 2'b00 : 2'b11});
			rdchk("condIdle", `A_COND, condWord(1'b0));
			rdchk("rdyDone", `A_CAL_RDY, 32'h0);
			chk("calWes", 2 * (i + 1), calWes);
		end
		// Local sensor selection shows the switch for the set span.
		for (i = 0; i < 2; i++) begin
			@(posedge mclk);
			sensSwPin <= 2'($random(seed));
			repeat (4) @(posedge mclk);
			localSensPin <= 1'b1;
			n = 0;
			for (j = 0; j < 40; j++) begin
				@(posedge mclk);
				#1;
				if (dispShow === 1'b1) n++;
			end
			localSensPin <= 1'b0;
			chk("showCycles", SHOW, n);
			chk("dispCode", sensSwPin, dispCode);
		end
		final_report();
	end
endmodule
